/* File: inc/emi_map.svh */
// register offsets, field positions and reset values of the memory bus
`ifndef EMI_MAP_SVH
`define EMI_MAP_SVH

`define EMI_OFF_GLOBAL      12'h000
`define EMI_OFF_PORTCFG     12'h004
`define EMI_OFF_STATUS      12'h008
`define EMI_OFF_CTRL0       12'h010
`define EMI_OFF_CTRL3       12'h01C
`define EMI_OFF_PROT0       12'h020
`define EMI_OFF_PROT3       12'h02C

`define EMI_GLOBAL_ON       32'h0000_0001
`define EMI_CTRL_RESET      2'h0
`define EMI_PROT_RESET      16'h00FF
`define EMI_PORTCFG_RESET   8'h00

`define EMI_CTRL_EN         0
`define EMI_CTRL_W16        1
`define EMI_PROT_BYTEGATE   15
`define EMI_PROT_ALE_HI     14
`define EMI_PROT_ALE_LO     12
`define EMI_PROT_ADDR16     11
`define EMI_PROT_NOHOLD     10
`define EMI_PROT_NORDTA     9
`define EMI_PROT_NOWRTA     8
`define EMI_PROT_WR_HI      7
`define EMI_PROT_WR_LO      4
`define EMI_PROT_RD_HI      3
`define EMI_PROT_RD_LO      0

`define EMI_PC_AD           0
`define EMI_PC_TOP          1
`define EMI_PC_SEL_LO       2
`define EMI_PC_STRB         6
`define EMI_PC_LANE         7

`define EMI_REGION_FIRST    4'h1
`define EMI_REGION_LAST     4'h4
`define EMI_SPAN_HI_ZERO    11'h000
`endif

/* File: inc/emi_pkg.sv */
// types shared by the external memory interface
package emi_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALE  = 3'b001,
    ST_HOLD = 3'b011,
    ST_PRE  = 3'b010,
    ST_STRB = 3'b110,
    ST_POST = 3'b111
  } bus_state_t;

  typedef struct packed {
    logic [15:0] ad_out;
    logic        ad_oe;
    logic        top_addr_bit;
    logic [3:0]  region_selects_n;
    logic        fetch_pulse_n;
    logic        store_pulse_window_n;
    logic        addr_latch_pulse;
    logic        upper_byte_lane_n;
    logic        lower_byte_lane_n;
  } pin_bus_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [15:0] wdata;
    logic [1:0]  be;
  } mem_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        done;
    logic        error;
  } mem_resp_t;

  typedef struct packed {
    logic             global_en;
    logic [7:0]       port_cfg;
    logic [3:0][1:0]  ctrl;
    logic [3:0][15:0] prot;
    bus_state_t       fsm;
    logic [3:0]       cnt;
    logic [1:0]       region;
    logic [15:0]      cur_prot;
    logic             cur_w16;
    logic             ready;
    mem_req_t         req;
    pin_bus_t         pins;
    mem_resp_t        resp;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } emi_state_t;

endpackage

/* File: core/external_memory_interface.sv */
// external memory bus controller with apb register file
//
// Function
// R01 - four 128 KiB regions routed to bus
// R02 - nothing works until global register holds 1
// R03 - each pin needs its own port setting; code shares one bit each across bus, strobes, lanes
// R04 - control bit 0 enables region
// R05 - control bit 1 selects 16-bit data
// R06 - protocol bit 15 gates lanes with write
// R07 - protocol bits 14:12 set latch wait states
// R08 - protocol bit 11 selects 16-bit addressing
// R09 - protocol bit 10 clear adds address hold
// R10 - protocol bit 9 clear pads read strobe
// R11 - protocol bit 8 clear pads write strobe
// R12 - bits 7:4 write strobe length, reset 0xF
// R13 - bits 3:0 read strobe length, reset 0xF
// R14 - muxed bus, top bit, selects, strobes, lanes
// R15 - address with latch pulse, then data strobe
// R16 - only addressed select, held whole cycle
// R17 - memory latches address, data within strobe
`timescale 1ns/1ps
`include "emi_map.svh"

module external_memory_interface (
  // clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // processor memory request
  input  wire logic                 req_valid,
  input  wire emi_pkg::mem_req_t    req,
  output logic                      req_ready,
  output emi_pkg::mem_resp_t        resp,
  // external bus pins
  input  wire logic [15:0]          ad_in,
  output emi_pkg::pin_bus_t         pins,
  output logic [7:0]                port_pin_ext
);

  emi_pkg::emi_state_t s_reg;
  emi_pkg::emi_state_t s_next;

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  // region index from address; bit 2 flags a hit
  function automatic logic [2:0] region_of(input logic [31:0] a);
    logic [3:0] top;
    top = a[31:28];
    if (top >= `EMI_REGION_FIRST && top <= `EMI_REGION_LAST &&
        a[27:17] == `EMI_SPAN_HI_ZERO) begin
      region_of = {1'b1, 2'(top - `EMI_REGION_FIRST)};
    end else begin
      region_of = 3'h0;
    end
  endfunction

  // idle levels of every pin
  function automatic emi_pkg::pin_bus_t idle_pins();
    emi_pkg::pin_bus_t p;
    p                      = '0;
    p.region_selects_n     = 4'hF;
    p.fetch_pulse_n        = 1'b1;
    p.store_pulse_window_n = 1'b1;
    p.upper_byte_lane_n    = 1'b1;
    p.lower_byte_lane_n    = 1'b1;
    idle_pins              = p;
  endfunction

  // pins without their port setting stay idle
  function automatic emi_pkg::pin_bus_t gate_pins(
    input emi_pkg::pin_bus_t p,
    input logic [7:0]        en
  );
    emi_pkg::pin_bus_t q;
    emi_pkg::pin_bus_t i;
    q = p;
    i = idle_pins();
    if (!en[`EMI_PC_AD]) begin
      q.ad_out = i.ad_out;
      q.ad_oe  = 1'b0;
    end
    if (!en[`EMI_PC_TOP]) begin
      q.top_addr_bit = i.top_addr_bit;
    end
    for (int k = 0; k < 4; k++) begin
      if (!en[`EMI_PC_SEL_LO + k]) begin
        q.region_selects_n[k] = 1'b1;
      end
    end
    if (!en[`EMI_PC_STRB]) begin
      q.fetch_pulse_n        = 1'b1;
      q.store_pulse_window_n = 1'b1;
      q.addr_latch_pulse     = 1'b0;
    end
    if (!en[`EMI_PC_LANE]) begin
      q.upper_byte_lane_n = 1'b1;
      q.lower_byte_lane_n = 1'b1;
    end
    gate_pins = q;
  endfunction

  //----------------------------------------------------------------
  // reset value
  //----------------------------------------------------------------
  // constant, so the async reset branch loads no logic output
  function automatic emi_pkg::emi_state_t reset_state();
    emi_pkg::emi_state_t s;
    s = '0;
    for (int k = 0; k < 4; k++) begin
      s.ctrl[k] = `EMI_CTRL_RESET;
      s.prot[k] = `EMI_PROT_RESET; // see R12 see R13
    end
    s.port_cfg  = `EMI_PORTCFG_RESET;
    s.fsm       = emi_pkg::ST_IDLE;
    s.ready     = 1'b1;
    s.pins      = idle_pins();
    reset_state = s;
  endfunction

  localparam emi_pkg::emi_state_t reset_value = reset_state();

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  always_comb begin
    logic [2:0]        hit;
    logic              w16;
    logic              a16;
    logic              pad;
    logic [1:0]        ri;
    emi_pkg::pin_bus_t p;
    hit = 3'h0;
    w16 = 1'b0;
    a16 = 1'b0;
    pad = 1'b0;
    ri  = 2'h0;
    p   = s_reg.pins;

    s_next            = s_reg;
    s_next.resp.done  = 1'b0;
    s_next.resp.error = 1'b0;
    s_next.pready     = 1'b0;
    s_next.pslverr    = 1'b0;

    // apb: answer in the first access cycle
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (paddr == `EMI_OFF_GLOBAL) begin
        s_next.prdata[0] = s_reg.global_en;
      end else if (paddr == `EMI_OFF_PORTCFG) begin
        s_next.prdata[7:0] = s_reg.port_cfg;
      end else if (paddr == `EMI_OFF_STATUS) begin
        s_next.prdata[0]   = !s_reg.ready;
        s_next.prdata[3:1] = s_reg.fsm;
        s_next.prdata[5:4] = s_reg.region;
      end else if (paddr >= `EMI_OFF_CTRL0 && paddr <= `EMI_OFF_CTRL3 &&
                   paddr[1:0] == 2'h0) begin
        s_next.prdata[1:0] = s_reg.ctrl[paddr[3:2]];
      end else if (paddr >= `EMI_OFF_PROT0 && paddr <= `EMI_OFF_PROT3 &&
                   paddr[1:0] == 2'h0) begin
        s_next.prdata[15:0] = s_reg.prot[paddr[3:2]];
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
    if (psel && penable && s_reg.pready && pwrite && !s_reg.pslverr) begin
      if (paddr == `EMI_OFF_GLOBAL) begin
        s_next.global_en = (pwdata == `EMI_GLOBAL_ON); // see R02
      end else if (paddr == `EMI_OFF_PORTCFG) begin
        s_next.port_cfg = pwdata[7:0]; // see R03
      end else if (paddr >= `EMI_OFF_CTRL0 && paddr <= `EMI_OFF_CTRL3) begin
        s_next.ctrl[paddr[3:2]] = pwdata[1:0];
      end else if (paddr >= `EMI_OFF_PROT0 && paddr <= `EMI_OFF_PROT3) begin
        s_next.prot[paddr[3:2]] = pwdata[15:0];
      end
    end

    // bus sequencer
    case (s_reg.fsm)
      emi_pkg::ST_IDLE: begin
        if (req_valid && s_reg.ready) begin
          hit = region_of(req.addr); // see R01
          ri  = hit[1:0];
          if (!hit[2] || !s_reg.global_en ||
              !s_reg.ctrl[ri][`EMI_CTRL_EN]) begin // see R02 see R04
            s_next.resp.error = 1'b1;
            s_next.resp.done  = 1'b1;
          end else begin
            s_next.req      = req;
            s_next.region   = ri;
            s_next.cur_prot = s_reg.prot[ri];
            s_next.cur_w16  = s_reg.ctrl[ri][`EMI_CTRL_W16]; // see R05
            s_next.ready    = 1'b0;
            s_next.fsm      = emi_pkg::ST_ALE;
            s_next.cnt      = {1'b0, s_reg.prot[ri][`EMI_PROT_ALE_HI:
                                                   `EMI_PROT_ALE_LO]};
            a16             = s_reg.prot[ri][`EMI_PROT_ADDR16];
            w16             = s_reg.ctrl[ri][`EMI_CTRL_W16];
            p               = idle_pins();
            // see R08
            p.ad_out        = a16 ? req.addr[15:0]
                                  : {8'h00, req.addr[7:0]};
            p.top_addr_bit  = a16 & req.addr[16];
            p.ad_oe         = 1'b1;
            p.addr_latch_pulse = 1'b1; // see R15 see R07
            p.region_selects_n[ri] = 1'b0; // see R16
            if (!s_reg.prot[ri][`EMI_PROT_BYTEGATE] || !req.write) begin
              p.upper_byte_lane_n = !(w16 & (req.be[1] | !req.write));
              p.lower_byte_lane_n = 1'b0;
            end
          end
        end
      end
      emi_pkg::ST_ALE: begin
        if (s_reg.cnt != 4'h0) begin
          s_next.cnt = s_reg.cnt - 4'h1; // see R07
        end else begin
          p.addr_latch_pulse = 1'b0;
          if (!s_reg.cur_prot[`EMI_PROT_NOHOLD]) begin
            s_next.fsm = emi_pkg::ST_HOLD; // see R09
          end else begin
            pad = s_reg.req.write ? !s_reg.cur_prot[`EMI_PROT_NOWRTA]
                                  : !s_reg.cur_prot[`EMI_PROT_NORDTA];
            s_next.fsm = pad ? emi_pkg::ST_PRE : emi_pkg::ST_STRB;
          end
        end
      end
      emi_pkg::ST_HOLD: begin
        pad = s_reg.req.write ? !s_reg.cur_prot[`EMI_PROT_NOWRTA]
                              : !s_reg.cur_prot[`EMI_PROT_NORDTA];
        s_next.fsm = pad ? emi_pkg::ST_PRE : emi_pkg::ST_STRB; // see R10 see R11
      end
      emi_pkg::ST_PRE: begin
        s_next.fsm = emi_pkg::ST_STRB;
      end
      default: begin
      end
    endcase

    // entering the strobe or the pad before it: data phase setup
    if (s_next.fsm == emi_pkg::ST_STRB && s_reg.fsm != emi_pkg::ST_STRB) begin
      s_next.cnt = s_reg.req.write
                 ? s_reg.cur_prot[`EMI_PROT_WR_HI:`EMI_PROT_WR_LO]  // see R12
                 : s_reg.cur_prot[`EMI_PROT_RD_HI:`EMI_PROT_RD_LO]; // see R13
      if (s_reg.req.write) begin
        p.ad_out = s_reg.cur_w16 ? s_reg.req.wdata
                                 : {8'h00, s_reg.req.wdata[7:0]};
        p.ad_oe  = 1'b1;
        p.store_pulse_window_n = 1'b0;
        if (s_reg.cur_prot[`EMI_PROT_BYTEGATE]) begin // see R06
          p.upper_byte_lane_n = !(s_reg.cur_w16 & s_reg.req.be[1]);
          p.lower_byte_lane_n = s_reg.cur_w16 & !s_reg.req.be[0];
        end
      end else begin
        p.ad_oe         = 1'b0;
        p.fetch_pulse_n = 1'b0; // see R15
      end
    end else if (s_next.fsm == emi_pkg::ST_PRE && s_reg.fsm != emi_pkg::ST_PRE) begin
      if (s_reg.req.write) begin
        p.ad_out = s_reg.cur_w16 ? s_reg.req.wdata
                                 : {8'h00, s_reg.req.wdata[7:0]};
      end else begin
        p.ad_oe = 1'b0; // release for the memory to drive
      end
    end

    if (s_reg.fsm == emi_pkg::ST_STRB) begin
      if (s_reg.cnt != 4'h0) begin
        s_next.cnt = s_reg.cnt - 4'h1;
      end else begin
        p.fetch_pulse_n        = 1'b1;
        p.store_pulse_window_n = 1'b1;
        if (s_reg.cur_prot[`EMI_PROT_BYTEGATE] && s_reg.req.write) begin
          p.upper_byte_lane_n = 1'b1;
          p.lower_byte_lane_n = 1'b1;
        end
        if (!s_reg.req.write) begin // see R17
          s_next.resp.rdata = s_reg.cur_w16 ? ad_in : {8'h00, ad_in[7:0]};
        end
        pad = s_reg.req.write ? !s_reg.cur_prot[`EMI_PROT_NOWRTA]
                              : !s_reg.cur_prot[`EMI_PROT_NORDTA];
        s_next.fsm = pad ? emi_pkg::ST_POST : emi_pkg::ST_IDLE; // see R10 see R11
      end
    end

    // end of the bus cycle
    if (s_next.fsm == emi_pkg::ST_IDLE && s_reg.fsm != emi_pkg::ST_IDLE) begin
      p                = idle_pins(); // see R16
      s_next.resp.done = 1'b1;
      s_next.ready     = 1'b1;
    end
    if (s_reg.fsm == emi_pkg::ST_POST) begin
      s_next.fsm       = emi_pkg::ST_IDLE;
      p                = idle_pins();
      s_next.resp.done = 1'b1;
      s_next.ready     = 1'b1;
    end

    s_next.pins = p;
  end

  //----------------------------------------------------------------
  // state register
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= reset_value;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  logic [7:0]        pin_en_reg;
  emi_pkg::pin_bus_t pins_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_reg <= `EMI_PORTCFG_RESET;
      pins_reg   <= reset_value.pins;
    end else if (ce) begin
      pin_en_reg <= s_next.global_en ? s_next.port_cfg : 8'h00; // see R03
      pins_reg   <= gate_pins(s_next.pins,
                              s_next.global_en ? s_next.port_cfg
                                               : 8'h00); // see R14
    end
  end

  assign pins         = pins_reg;
  assign port_pin_ext = pin_en_reg;
  assign pready       = s_reg.pready;
  assign pslverr      = s_reg.pslverr;
  assign prdata       = s_reg.prdata;
  assign req_ready    = s_reg.ready;
  assign resp         = s_reg.resp;

endmodule

/* File: sim/emi_mem_model.sv */
// behavioural parallel memory on the multiplexed bus
`timescale 1ns/1ps

module emi_mem_model (
  // clock
  input  wire logic              pclk,
  // bus pins
  input  wire emi_pkg::pin_bus_t pins,
  output logic [15:0]            ad_in
);
  logic [15:0] mem [256];
  logic [7:0]  lat;
  logic [15:0] last;

  initial begin
    lat  = 8'h00;
    last = 16'h0000;
    for (int k = 0; k < 256; k++) begin
      mem[k] = 16'(k * 257);
    end
  end

  always @(posedge pclk) begin
    if (pins.addr_latch_pulse) begin
      lat <= pins.ad_out[7:0];
    end
    if (!pins.store_pulse_window_n && !pins.lower_byte_lane_n) begin
      mem[lat][7:0] <= pins.ad_out[7:0];
    end
    if (!pins.store_pulse_window_n && !pins.upper_byte_lane_n) begin
      mem[lat][15:8] <= pins.ad_out[15:8];
    end
    last <= ad_in;
  end

  // released bus shows a changing pattern, never the last value
  always_comb begin
    if (pins.ad_oe) begin
      ad_in = pins.ad_out;
    end else if (!pins.fetch_pulse_n) begin
      ad_in = mem[lat];
    end else begin
      ad_in = ~last;
    end
  end
endmodule

/* File: sim/emi_assertions.sv */
// concurrent checks on the memory interface ports
`timescale 1ns/1ps

module emi_assertions (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  // memory request
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire emi_pkg::mem_resp_t resp,
  // pins
  input wire emi_pkg::pin_bus_t  pins,
  input wire logic [7:0]         port_pin_ext
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  region_miss_a: assert property (
    req_valid && req_ready |=> !req_ready || (resp.done && resp.error))
    else $error("refused request not answered at once");
  sel_onehot_a: assert property ($onehot0(~pins.region_selects_n))
    else $error("more than one select");
  sel_steady_a: assert property (
    $changed(pins.region_selects_n) |-> $changed(req_ready))
    else $error("select moved inside a cycle");
  strobe_excl_a: assert property (
    !(!pins.fetch_pulse_n && !pins.store_pulse_window_n))
    else $error("both strobes low");
  latch_drives_a: assert property (
    pins.addr_latch_pulse && port_pin_ext[0]
      |-> pins.ad_oe && pins.fetch_pulse_n && pins.store_pulse_window_n)
    else $error("latch pulse without address");
  fetch_float_a: assert property (!pins.fetch_pulse_n |-> !pins.ad_oe)
    else $error("bus driven during read");
  sel_gated_a: assert property (
    (~pins.region_selects_n & ~port_pin_ext[5:2]) == 4'h0)
    else $error("select on a disabled pin");
  strobe_gated_a: assert property (
    !pins.fetch_pulse_n || !pins.store_pulse_window_n |-> port_pin_ext[6])
    else $error("strobe on a disabled pin");

  cover property (!pins.fetch_pulse_n);
  cover property (!pins.store_pulse_window_n);
  cover property (resp.done && resp.error);
endmodule

bind external_memory_interface emi_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
  .req_ready(req_ready), .resp(resp), .pins(pins),
  .port_pin_ext(port_pin_ext));

/* File: sim/external_memory_interface_bench.sv */
// self-checking bench of the external memory interface
`timescale 1ns/1ps
`include "emi_map.svh"

module external_memory_interface_bench;
  logic               pclk, presetn, ce, psel, penable, pwrite, pready;
  logic               pslverr, req_valid, req_ready, perr, top, lane, err;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, q, a;
  logic [15:0]        ad_in, ad, rd, d, p;
  logic [7:0]         port_pin_ext;
  logic [3:0]         sel;
  logic [1:0]         r;
  logic               w16;
  emi_pkg::mem_req_t  req;
  emi_pkg::mem_resp_t resp;
  emi_pkg::pin_bus_t  pins;
  int                 err_total, cmp_count, seed, cyc, n;

  external_memory_interface i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp(resp),
    .ad_in(ad_in), .pins(pins), .port_pin_ext(port_pin_ext));
  emi_mem_model i_mem (.pclk(pclk), .pins(pins), .ad_in(ad_in));

  always #2.5 pclk = ~pclk;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] ad_r, input logic wr,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= ad_r;
    pwrite  <= wr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q       = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mreq(input logic [31:0] ma, input logic wr,
                      input logic [15:0] wd, input logic [1:0] be);
    @(posedge pclk);
    req_valid <= 1;
    req <= '{ma, wr, wd, be};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 0;
    n = 0; sel = 4'hF; lane = 0; ad = 16'h0000; top = 0;
    do begin
      @(posedge pclk);
      n++;
      if (pins.addr_latch_pulse) begin
        ad = pins.ad_out;
        top = pins.top_addr_bit;
      end
      sel &= pins.region_selects_n;
      if (wr && pins.store_pulse_window_n && !pins.lower_byte_lane_n) lane = 1;
    end while (resp.done !== 1'b1 && n < 100);
    err = resp.error;
    rd = resp.rdata;
  endtask

  // cycles from take to done for a protocol word
  function automatic int exp_n(input logic [15:0] pw, input logic wr);
    int pad;
    pad = wr ? !pw[8] : !pw[9];
    return int'(pw[14:12]) + 1 + !pw[10] + 2 * pad
           + int'(wr ? pw[7:4] : pw[3:0]) + 2;
  endfunction

  initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; req_valid = 0; req = '0;
    err_total = 0; cmp_count = 0; cyc = 0; seed = 24473;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(`EMI_OFF_GLOBAL, 0, 0); chk(q, 0);
    apb(`EMI_OFF_PORTCFG, 0, 0); chk(q, 0);
    for (int i = 0; i < 4; i++) begin
      apb(12'(`EMI_OFF_CTRL0 + 4 * i), 0, 0); chk(q, 0);
      apb(12'(`EMI_OFF_PROT0 + 4 * i), 0, 0); chk(q, 32'hFF);
    end
    apb(12'h0FC, 0, 0); chk(perr, 1);
    apb(`EMI_OFF_STATUS, 0, 0); chk(q, 0);
    mreq(32'h1000_0000, 0, 0, 3); chk({err, 8'(n)}, 9'h101);
    $display("test reset and refusal done");
    apb(`EMI_OFF_GLOBAL, 1, 1); apb(`EMI_OFF_PORTCFG, 1, 32'hFF);
    repeat (2) @(negedge pclk);
    chk(port_pin_ext, 8'hFF);
    mreq(32'h2000_0000, 0, 0, 3); chk({err, 8'(n)}, 9'h101);
    for (int i = 0; i < 4; i++) apb(12'(`EMI_OFF_CTRL0 + 4 * i), 1, 3);
    mreq(32'h1002_0000, 0, 0, 3); chk(err, 1);
    mreq(32'h5000_0000, 0, 0, 3); chk(err, 1);
    $display("test region decode done");
    for (int i = 0; i < 24; i++) begin
      r = 2'($random(seed));
      p = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed));
      w16 = i < 2 ? 1'b1 : 1'($random(seed));
      a = {4'(r) + 4'h1, 11'h000, 17'($random(seed))};
      d = 16'($random(seed));
      apb(12'(`EMI_OFF_PROT0 + 4 * r), 1, {16'h0, p});
      apb(12'(`EMI_OFF_CTRL0 + 4 * r), 1, {30'h0, w16, 1'b1});
      mreq(a, 1, d, {w16, 1'b1});
      chk(n, exp_n(p, 1));
      chk(lane, !p[15]);
      mreq(a, 0, 0, 3);
      chk(n, exp_n(p, 0));
      chk(sel, 4'(~(4'h1 << r)));
      chk(ad, p[11] ? a[15:0] : {8'h00, a[7:0]});
      chk(top, p[11] & a[16]);
      chk(err, 0);
      chk(w16 ? rd : rd[7:0], w16 ? d : d[7:0]);
    end
    $display("test random accesses done");
    apb(`EMI_OFF_PORTCFG, 1, 0);
    mreq(32'h1000_0010, 0, 0, 3); chk(sel, 4'hF);
    apb(`EMI_OFF_PORTCFG, 1, 32'hFF); apb(`EMI_OFF_GLOBAL, 1, 2);
    repeat (2) @(negedge pclk);
    chk(port_pin_ext, 0);
    mreq(32'h1000_0010, 0, 0, 3); chk(err, 1);
    $display("test pin gating done");
    print_verdict;
  end
endmodule
